// ### plc_ctrl.sv
// Notes on behaviour
// R1 - Thirty-two lines, each independently programmable.
// R2 - Each line owned by the controller or by a peripheral.
// R3 - Line n is bit n in every register.
// R4 - A change of a sampled line level sets its change flag, interrupting if the line's interrupt is enabled.
// R5 - Optional per-line filter drops pulses shorter than half a clock.
// R6 - Multi-drive mode only pulls the line low, never high.
// R7 - Pull-up of each line switched on and off by software.
// R8 - Software reads line level, sets output value and drive enable.
// R9 - One write updates output data of all 32 lines.
// R10 - Product wiring fixes which lines carry one or two peripherals.
// R11 - Lines without peripheral ignore hand-over writes; controller drives them.
// R12 - Interrupt inputs always see the pin level, never blocked.
// R13 - Register writes work while the controller clock is gated.
// R14 - Change detection and level reading run only with clock on.
// R15 - Controller clock is off after reset until enabled.
// R16 - Software enables the clock before trusting line input data.
// R17 - Interrupt output goes to a peripheral source 2 to 31.
// R18 - No interrupt is raised while the controller clock is gated.
// R19 - Owner status reads 1 for controller, 0 for peripheral.
// R20 - Peripheral choice reads 0 for first, 1 for second function.
module plc_ctrl
    import plc_pkg::*;
(
    input  wire logic        pclk,          // Bus clock
    input  wire logic        presetn,       // Async reset, low
    input  wire logic        psel,          // APB select
    input  wire logic        penable,       // APB access phase
    input  wire logic        pwrite,        // APB direction
    input  wire logic [7:0]  paddr,         // APB byte address
    input  wire logic [31:0] pwdata,        // APB write data
    output logic      [31:0] prdata,        // APB read data
    output logic             pready,        // APB ready
    output logic             pslverr,       // APB error
    input  wire logic        clk_en,        // Clock enable from power mgr
    input  wire logic [31:0] pad_in,        // Pin levels, async
    output logic      [31:0] pad_out,       // Pin output value
    output logic      [31:0] pad_oe,        // Pin output enable
    output logic      [31:0] pad_pu_en,     // Pull-up enable
    input  plc_drive_t       per_a,         // First peripheral drive
    input  plc_drive_t       per_b,         // Second peripheral drive
    output logic      [31:0] line_level,    // Pin level to peripherals
    output logic             irq            // Change interrupt
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    // One vector bit per line, bit n is line n everywhere
    logic [31:0] own_q, oe_q, flt_q, out_q, ien_q; // R1 R3
    logic [31:0] chg_q, md_q, pudis_q, sel_q, pu_en_q;
    logic [31:0] s1_q, s2_q, s3_q, lvl_q, lvl_d, chg_d;
    logic [31:0] prdata_q, drv_val_q, drv_oe_q;
    logic        pready_q, pslverr_q, clk_on_q, irq_q;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    wire         fire  = psel & penable & pready_q;
    wire         wr    = fire & pwrite;
    wire         rd_go = psel & penable & ~pready_q & ~pwrite;
    wire  [31:0] wd    = pwdata;
    function automatic logic hit(input logic [7:0] off);
        hit = wr && (paddr == off);
    endfunction

    // Set/clear style update; set and clear of one bit: clear wins
    function automatic logic [31:0] sc(input logic [31:0] q,
                                       input logic s, input logic c);
        sc = (q | (s ? wd : 32'h0)) & ~(c ? wd : 32'h0);
    endfunction

    // Hand-over only reaches lines with a peripheral behind them
    wire  [31:0] own_d = sc(own_q, hit(PLC_OWN_SET), hit(PLC_OWN_CLR))
                       | ~PLC_MUX_MASK; // R11
    // Second function only where the product wires one
    wire  [31:0] sel_d = sc(sel_q, hit(PLC_SEL_B), hit(PLC_SEL_A))
                       & PLC_B_MASK; // R10
    wire  [31:0] out_d = hit(PLC_OUT_DATA) ? wd :
                         sc(out_q, hit(PLC_OUT_SET), hit(PLC_OUT_CLR)); // R9
    // Status bit set means pull-up off; the pin gets the inverse
    wire  [31:0] pudis_d = sc(pudis_q, hit(PLC_PU_DIS), hit(PLC_PU_EN));

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    logic [31:0] rmux;
    logic        rerr;
    always_comb begin
        rerr = 1'b0;
        unique case (paddr)
            PLC_OWN_STAT: rmux = own_q; // R19
            PLC_OE_STAT:  rmux = oe_q;
            PLC_FLT_STAT: rmux = flt_q;
            PLC_OUT_DATA: rmux = out_q;
            PLC_PIN_LVL:  rmux = lvl_q; // R8
            PLC_IEN_STAT: rmux = ien_q;
            PLC_CHG_STAT: rmux = chg_q;
            PLC_MD_STAT:  rmux = md_q;
            PLC_PU_STAT:  rmux = pudis_q;
            PLC_SEL_STAT: rmux = sel_q; // R20
            default: begin
                rmux = 32'h0;
                rerr = 1'b1;
            end
        endcase
    end
    wire         rd_chg = fire & ~pwrite & (paddr == PLC_CHG_STAT);

    // ----------------------------------------
    // Input sampling and filter
    // ----------------------------------------
    // Two samples must agree on filtered lines; a pulse under half a
    // clock can at most hit one sample, so it never gets through.
    wire  [31:0] agree = ~(s2_q ^ s3_q);
    wire  [31:0] filt  = (s2_q & ~flt_q) |
                         (flt_q & ((agree & s2_q) | (~agree & lvl_q))); // R5
    // Sampling frozen while the clock is gated
    assign lvl_d = clk_on_q ? filt : lvl_q; // R14
    // Read-to-clear loses to a fresh change in the same cycle
    assign chg_d = (rd_chg ? 32'h0 : chg_q)
                 | (clk_on_q ? (filt ^ lvl_q) : 32'h0); // R4

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    wire  [31:0] p_val = (sel_q & per_b.val) | (~sel_q & per_a.val);
    wire  [31:0] p_oe  = (sel_q & per_b.oe)  | (~sel_q & per_a.oe);
    wire  [31:0] m_val = (own_q & out_q) | (~own_q & p_val); // R2
    wire  [31:0] m_oe  = (own_q & oe_q)  | (~own_q & p_oe);
    // Multi-drive lines only ever drive a zero
    wire  [31:0] d_oe  = (md_q & m_oe & ~m_val) | (~md_q & m_oe); // R6
    wire  [31:0] d_val = ~md_q & m_val;

    // ----------------------------------------
    // Bus handshake, one wait state
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= PLC_ZERO_RST;
        end else begin
            pready_q  <= psel & penable & ~pready_q;
            pslverr_q <= rd_go & rerr;
            prdata_q  <= rd_go ? rmux : 32'h0;
        end
    end

    // ----------------------------------------
    // Configuration, written whatever the clock enable says
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            own_q   <= PLC_OWN_RST;
            oe_q    <= PLC_ZERO_RST;
            flt_q   <= PLC_ZERO_RST;
            out_q   <= PLC_ZERO_RST;
            ien_q   <= PLC_ZERO_RST;
            md_q    <= PLC_ZERO_RST;
            pudis_q <= PLC_ZERO_RST;
            sel_q   <= PLC_ZERO_RST;
        end else begin
            own_q   <= own_d;                                     // R13
            oe_q    <= sc(oe_q, hit(PLC_OE_SET), hit(PLC_OE_CLR));
            flt_q   <= sc(flt_q, hit(PLC_FLT_SET), hit(PLC_FLT_CLR));
            out_q   <= out_d;
            ien_q   <= sc(ien_q, hit(PLC_IEN_SET), hit(PLC_IEN_CLR));
            md_q    <= sc(md_q, hit(PLC_MD_SET), hit(PLC_MD_CLR));
            pudis_q <= pudis_d;                                   // R7
            sel_q   <= sel_d;
        end
    end

    // ----------------------------------------
    // Synchroniser, level, change flags, interrupt
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q     <= PLC_ZERO_RST;
            s2_q     <= PLC_ZERO_RST;
            s3_q     <= PLC_ZERO_RST;
            lvl_q    <= PLC_ZERO_RST;
            chg_q    <= PLC_ZERO_RST;
            clk_on_q <= 1'b0; // R15
            irq_q    <= 1'b0;
        end else begin
            s1_q     <= pad_in;
            s2_q     <= s1_q;
            s3_q     <= s2_q;
            lvl_q    <= lvl_d;
            chg_q    <= chg_d;
            clk_on_q <= clk_en;
            irq_q    <= clk_on_q & |(chg_q & ien_q); // R18
        end
    end

    // ----------------------------------------
    // Registered pin outputs
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drv_val_q <= PLC_ZERO_RST;
            drv_oe_q  <= PLC_ZERO_RST;
            pu_en_q   <= ~PLC_ZERO_RST; // Pull-ups start switched on
        end else begin
            drv_val_q <= d_val;
            drv_oe_q  <= d_oe;
            pu_en_q   <= ~pudis_d;
        end
    end

    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;
    assign pad_out    = drv_val_q;
    assign pad_oe     = drv_oe_q;
    assign pad_pu_en  = pu_en_q;
    // Ungated: interrupt inputs and peripherals always see the pin
    assign line_level = s2_q; // R12
    assign irq        = irq_q; // R17

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    irq_gated_a: assert property (!clk_on_q |=> !irq_q) // R18
        else $error("interrupt while clock gated");
    own_fixed_a: assert property ((~PLC_MUX_MASK & ~own_q) == 32'h0) // R11
        else $error("unmuxed line handed to peripheral");
    chg_set_a: assert property (clk_on_q && (filt != lvl_q) // R4
        |=> ((chg_q & $past(filt ^ lvl_q)) == $past(filt ^ lvl_q)))
        else $error("level change not flagged");
    lvl_freeze_a: assert property (!clk_on_q |=> $stable(lvl_q)) // R14
        else $error("level moved with clock gated");
    sync_write_a: assert property (wr && paddr == PLC_OUT_DATA // R9
        |=> out_q == $past(pwdata))
        else $error("output data write lost");
    cfg_noclk_a: assert property (!clk_on_q && wr && paddr == PLC_OE_SET // R13
        |=> (oe_q & $past(pwdata)) == $past(pwdata))
        else $error("write ignored while clock gated");
    md_low_a: assert property ((drv_oe_q & drv_val_q & $past(md_q)) // R6
        == 32'h0)
        else $error("multi-drive line driven high");
    pu_track_a: assert property (wr && paddr == PLC_PU_DIS // R7
        |=> (pad_pu_en & $past(pwdata)) == 32'h0)
        else $error("pull-up not switched off");
    sel_b_a: assert property (wr && paddr == PLC_SEL_B // R20
        |=> (sel_q & $past(pwdata & PLC_B_MASK))
            == $past(pwdata & PLC_B_MASK))
        else $error("second function not selected");
    ready_pulse_a: assert property (pready_q |=> !pready_q)
        else $error("ready held two cycles");

    // ----------------------------------------
    // Read data, level tracking, change flags, interrupt, pin ownership and pull-ups
    // ----------------------------------------
    // Read data was captured a cycle before the ready pulse
    own_rd_a: assert property (pready_q && !pwrite // R19
        && paddr == PLC_OWN_STAT |-> prdata_q == $past(own_q))
        else $error("owner status read wrong");
    sel_rd_a: assert property (pready_q && !pwrite // R20
        && paddr == PLC_SEL_STAT |-> prdata_q == $past(sel_q))
        else $error("choice status read wrong");
    lvl_rd_a: assert property (pready_q && !pwrite // R8
        && paddr == PLC_PIN_LVL |-> prdata_q == $past(lvl_q))
        else $error("pin level read wrong");

    // Unfiltered lines follow the second sync flop with the clock on
    lvl_track_a: assert property (clk_on_q // R14
        |=> ((lvl_q ^ $past(s2_q)) & ~$past(flt_q)) == 32'h0)
        else $error("level did not follow pin");
    // Filtered lines hold while their two samples disagree
    filt_hold_a: assert property (clk_on_q // R5
        |=> ((lvl_q ^ $past(lvl_q)) & $past(flt_q & (s2_q ^ s3_q)))
            == 32'h0)
        else $error("filtered line let a glitch through");
    chg_hold_a: assert property (!clk_on_q && !rd_chg // R14
        |=> $stable(chg_q))
        else $error("change flag moved with clock gated");
    chg_clear_a: assert property (rd_chg && !clk_on_q // R4
        |=> chg_q == 32'h0)
        else $error("change flags not cleared by read");
    irq_src_a: assert property (clk_on_q && (chg_q & ien_q) != 32'h0 // R17
        |=> irq_q)
        else $error("enabled change gave no interrupt");
    // Interrupt inputs see the pin even with the clock gated
    line_ungated_a: assert property (!clk_on_q // R12
        |=> line_level == $past(s1_q))
        else $error("line level blocked");

    // Controller-owned push-pull lines show the output register
    own_pin_a: assert property (((drv_val_q ^ $past(out_q)) // R2
        & $past(own_q & ~md_q)) == 32'h0)
        else $error("owned line not driven from register");
    own_clr_a: assert property (wr && paddr == PLC_OWN_CLR // R2
        |=> (own_q & $past(pwdata & PLC_MUX_MASK)) == 32'h0)
        else $error("line not handed to peripheral");
    out_set_a: assert property (wr && paddr == PLC_OUT_SET // R8
        |=> (out_q & $past(pwdata)) == $past(pwdata))
        else $error("output bit not set");
    pu_on_a: assert property (wr && paddr == PLC_PU_EN // R7
        |=> (pad_pu_en & $past(pwdata)) == $past(pwdata))
        else $error("pull-up not switched on");
endmodule

// ### plc_pkg.sv
package plc_pkg;
    // ----------------------------------------
    // Sizes and product configuration
    // ----------------------------------------
    localparam int          PLC_LINES     = 32;
    // Lines that have a peripheral behind them (product wiring)
    localparam logic [31:0] PLC_MUX_MASK  = 32'hffffffff;
    // Lines that have a second peripheral (B) behind them
    localparam logic [31:0] PLC_B_MASK    = 32'hffffffff;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] PLC_OWN_SET    = 8'h00;
    localparam logic [7:0] PLC_OWN_CLR    = 8'h04;
    localparam logic [7:0] PLC_OWN_STAT   = 8'h08;
    localparam logic [7:0] PLC_OE_SET     = 8'h10;
    localparam logic [7:0] PLC_OE_CLR     = 8'h14;
    localparam logic [7:0] PLC_OE_STAT    = 8'h18;
    localparam logic [7:0] PLC_FLT_SET    = 8'h20;
    localparam logic [7:0] PLC_FLT_CLR    = 8'h24;
    localparam logic [7:0] PLC_FLT_STAT   = 8'h28;
    localparam logic [7:0] PLC_OUT_SET    = 8'h30;
    localparam logic [7:0] PLC_OUT_CLR    = 8'h34;
    localparam logic [7:0] PLC_OUT_DATA   = 8'h38;
    localparam logic [7:0] PLC_PIN_LVL    = 8'h3c;
    localparam logic [7:0] PLC_IEN_SET    = 8'h40;
    localparam logic [7:0] PLC_IEN_CLR    = 8'h44;
    localparam logic [7:0] PLC_IEN_STAT   = 8'h48;
    localparam logic [7:0] PLC_CHG_STAT   = 8'h4c;
    localparam logic [7:0] PLC_MD_SET     = 8'h50;
    localparam logic [7:0] PLC_MD_CLR     = 8'h54;
    localparam logic [7:0] PLC_MD_STAT    = 8'h58;
    localparam logic [7:0] PLC_PU_DIS     = 8'h60;
    localparam logic [7:0] PLC_PU_EN      = 8'h64;
    localparam logic [7:0] PLC_PU_STAT    = 8'h68;
    localparam logic [7:0] PLC_SEL_A      = 8'h70;
    localparam logic [7:0] PLC_SEL_B      = 8'h74;
    localparam logic [7:0] PLC_SEL_STAT   = 8'h78;

    // ----------------------------------------
    // Values after reset
    // ----------------------------------------
    localparam logic [31:0] PLC_OWN_RST   = 32'hffffffff;
    localparam logic [31:0] PLC_ZERO_RST  = 32'h00000000;

    // Drive request from one peripheral function
    typedef struct packed {
        logic [31:0] val;
        logic [31:0] oe;
    } plc_drive_t;
endpackage

// ### plc_pads_model.sv
module plc_pads_model (
    input  wire logic        pclk,      // Bench clock
    input  wire logic [31:0] pad_out,   // Controller pin value
    input  wire logic [31:0] pad_oe,    // Controller drive enable
    input  wire logic [31:0] pad_pu_en, // Pull-up enable
    input  wire logic [31:0] ext_val,   // External device value
    input  wire logic [31:0] ext_oe,    // External device drive
    output logic      [31:0] pad_in     // Resolved pin level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] float_q = 32'h55555555;

    // Floating pins wander, so a stale level never looks valid
    always @(posedge pclk) begin
        float_q <= ~float_q;
    end

    // Controller drive wins, then the device, then the pull-up
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_oe & ext_val)
                  | (~pad_oe & ~ext_oe & (pad_pu_en | float_q));
endmodule

// ### tb.sv
module tb
    import plc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        clk_en;
    logic        irq;
    logic        err_q;
    logic [31:0] pad_in, pad_out, pad_oe, pad_pu_en, line_level;
    logic [31:0] ext_val, ext_oe, rd_q;
    plc_drive_t  per_a, per_b;
    int          n_mismatch;
    int          checks;
    int          cycles;

    plc_ctrl plc_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .clk_en, .pad_in, .pad_out,
        .pad_oe, .pad_pu_en, .per_a, .per_b, .line_level, .irq);
    plc_pads_model plc_pads_model_i (.pclk, .pad_out, .pad_oe, .pad_pu_en,
        .ext_val, .ext_oe, .pad_in);

    // ----------------------------------------
    // Clock and hang guard
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Whole sequence needs under 1000 cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic give_verdict();
        if (n_mismatch == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'h1, {31'h0, pready});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd_q);
    endtask

    task automatic w(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, clk_en} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ext_val = 32'h0;
        ext_oe = 32'h0;
        per_a = '0;
        per_b = '0;
        w(6);
        presetn <= 1'b1;
        rd(PLC_OWN_STAT, PLC_OWN_RST, "own_stat");
        rd(PLC_SEL_STAT, 32'h0, "sel_stat");
        rd(PLC_PU_STAT, 32'h0, "pu_stat");
        chk("pad_pu_en", 32'hffffffff, pad_pu_en);
        rd(8'h0c, 32'h0, "unmapped");
        chk("slverr", 32'h1, {31'h0, err_q});
        wr(8'h0c, 32'hffffffff);
        wr(PLC_OWN_STAT, 32'h0);
        rd(PLC_OWN_STAT, PLC_OWN_RST, "own_ro");
        // Clock still gated: writes must land anyway
        wr(PLC_OUT_DATA, 32'ha5a55a5a);
        w(2);
        chk("pad_out", 32'ha5a55a5a, pad_out);
        wr(PLC_OUT_DATA, 32'h000000f0);
        wr(PLC_OE_SET, 32'h000000ff);
        w(2);
        chk("pad_oe", 32'h000000ff, pad_oe);
        w(4);
        chk("line_level", 32'hfffffff0, line_level);
        rd(PLC_PIN_LVL, 32'h0, "pin_lvl_off");
        wr(PLC_IEN_SET, 32'hffffffff);
        w(10);
        chk("irq_off", 32'h0, {31'h0, irq});
        clk_en <= 1'b1;
        w(10);
        chk("irq_on", 32'h1, {31'h0, irq});
        rd(PLC_CHG_STAT, 32'hfffffff0, "chg_all");
        rd(PLC_PIN_LVL, 32'hfffffff0, "pin_lvl");
        w(4);
        chk("irq_clr", 32'h0, {31'h0, irq});
        ext_oe <= 32'h00100000;
        w(10);
        rd(PLC_CHG_STAT, 32'h00100000, "chg_l20");
        rd(PLC_PIN_LVL, 32'hffeffff0, "pin_l20");
        ext_oe <= 32'h0;
        w(10);
        rd(PLC_CHG_STAT, 32'h00100000, "chg_l20r");
        // One-cycle low pulse on a filtered and an open line
        wr(PLC_FLT_SET, 32'h00200000);
        rd(PLC_FLT_STAT, 32'h00200000, "flt_stat");
        ext_oe <= 32'h00600000;
        w(1);
        ext_oe <= 32'h0;
        w(10);
        rd(PLC_CHG_STAT, 32'h00400000, "chg_glitch");
        clk_en <= 1'b0;
        w(2);
        ext_oe <= 32'h00100000;
        w(10);
        chk("irq_gated", 32'h0, {31'h0, irq});
        rd(PLC_CHG_STAT, 32'h0, "chg_gated");
        ext_oe <= 32'h0;
        // Multi-drive line only pulls low
        wr(PLC_MD_SET, 32'h00000100);
        wr(PLC_OE_SET, 32'h00000100);
        wr(PLC_OUT_SET, 32'h00000100);
        w(2);
        chk("md_high", 32'h000000ff, pad_oe);
        wr(PLC_OUT_CLR, 32'h00000100);
        w(2);
        chk("md_low", 32'h000001ff, pad_oe);
        rd(PLC_OUT_DATA, 32'h000000f0, "out_data");
        // Hand line 10 to peripheral A, then B, then back
        per_a <= '{val: 32'h00000400, oe: 32'h00000400};
        per_b <= '{val: 32'h0, oe: 32'h00000400};
        wr(PLC_OWN_CLR, 32'h00000400);
        rd(PLC_OWN_STAT, 32'hfffffbff, "own_per");
        chk("per_a_out", 32'h000004f0, pad_out);
        chk("per_a_oe", 32'h000005ff, pad_oe);
        wr(PLC_SEL_B, 32'h00000400);
        rd(PLC_SEL_STAT, 32'h00000400, "sel_b");
        chk("per_b_out", 32'h000000f0, pad_out);
        wr(PLC_SEL_A, 32'h00000400);
        wr(PLC_OWN_SET, 32'h00000400);
        w(2);
        chk("own_back", 32'h000001ff, pad_oe);
        wr(PLC_PU_DIS, 32'h00000200);
        rd(PLC_PU_STAT, 32'h00000200, "pu_dis");
        chk("pu_off", 32'hfffffdff, pad_pu_en);
        wr(PLC_PU_EN, 32'h00000200);
        w(2);
        chk("pu_on", 32'hffffffff, pad_pu_en);
        give_verdict();
    end
endmodule
